// file: tb/dso_far_equipment.sv
// Far-side equipment counting contactor closures.
`default_nettype none
module dso_far_equipment (
  // Clock and reset
  input  wire logic  mclk,
  input  wire logic  reset_n,
  // Terminals
  input  wire logic  contactor_control,
  output logic [7:0] closure_cnt_q
);
  logic on_q;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      on_q          <= 1'b0;
      closure_cnt_q <= 8'h00;
    end else begin
      on_q          <= contactor_control;
      closure_cnt_q <= closure_cnt_q + {7'h00, contactor_control & !on_q};
    end
  end
endmodule
`default_nettype wire

// file: tb/dso_status_outputs_properties.sv
// Concurrent checks on the ports of the drive status outputs.
`default_nettype none
module dso_chk #(
  parameter int CYCLES_PER_MS = 10
) (
  // Clock, reset and drive inputs
  input wire logic               mclk,
  input wire logic               reset_n,
  input wire logic               pattern_active,
  input wire logic [2:0]         pattern_stage,
  input wire logic signed [15:0] torque_value,
  input wire logic               rotating_reverse,
  input wire logic               hw_prep_done,
  input wire logic               protect_active,
  input wire logic               run_cmd,
  input wire logic               coast_cmd,
  input wire logic               alarm,
  input wire logic               dc_braking,
  input wire dso_pkg::dso_temp_t heatsink_temp,
  input wire dso_pkg::dso_temp_t trip_temp,
  // Status outputs
  input wire logic               running_flag,
  input wire logic               torque_braking,
  input wire logic               ready_flag,
  input wire logic               contactor_control,
  input wire logic               output_limiting,
  input wire logic               heatsink_warning,
  input wire logic               stage_bit_w1,
  input wire logic               stage_bit_w2,
  input wire logic               stage_bit_w4
);
  import dso_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire logic   heat_hot = ({1'b0, heatsink_temp} + 9'h005) >= {1'b0, trip_temp};
  logic [15:0] lim_q;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lim_q <= 16'h0000;
    end else begin
      lim_q <= output_limiting ? lim_q + 16'h0001 : 16'h0000;
    end
  end
  a_stage_code: assert property (
    pattern_active |=> {stage_bit_w4, stage_bit_w2, stage_bit_w1} == $past(pattern_stage))
    else $error("stage code wrong");
  a_torque_sign: assert property (
    $past(reset_n) |-> torque_braking == $past(torque_value[15] ^ rotating_reverse))
    else $error("polarity wrong");
  a_ready_gate: assert property (
    ready_flag |-> $past(hw_prep_done && !protect_active))
    else $error("ready too early");
  a_coast_drop: assert property (
    coast_cmd || alarm |-> ##2 !contactor_control)
    else $error("contactor held");
  a_contactor_cause: assert property (
    $rose(contactor_control) |-> $past(run_cmd, 2))
    else $error("contactor uncaused");
  a_limit_width: assert property (
    $fell(output_limiting) |-> int'(lim_q) >= 99 * CYCLES_PER_MS)
    else $error("limiting too short");
  a_heat_on: assert property (
    heat_hot [*2] |=> heatsink_warning)
    else $error("no heat warning");
  a_brake_run: assert property (
    dc_braking [*2] |=> !running_flag)
    else $error("running in braking");
endmodule
bind dso_status_outputs dso_chk #(.CYCLES_PER_MS(CYCLES_PER_MS)) dso_chk_i (.*);
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the drive status outputs.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CPM = 10;
  logic mclk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'hf, limit_actions = 4'h0;
  logic pready, pslverr;
  dso_pkg::dso_freq_t out_freq = 16'h0, ref_freq = 16'h64, prelimit_freq;
  logic [15:0] dc_voltage = 16'h200, sync_angle_err = 16'h0;
  logic signed [15:0] torque_value = 16'h0;
  dso_pkg::dso_temp_t heatsink_temp = 8'h0, trip_temp = 8'h64;
  logic rotating_reverse = 1'b0, drive_running = 1'b0, dc_braking = 1'b0;
  logic pre_excitation = 1'b0, zero_speed_ctl = 1'b0, ride_through_run = 1'b0;
  logic uv_shutdown = 1'b0, hw_prep_done = 1'b0, protect_active = 1'b0, run_cmd = 1'b0;
  logic stop_cmd = 1'b0, coast_cmd = 1'b0, alarm = 1'b0, motor_stopped = 1'b0;
  logic pattern_active = 1'b0, fan_running = 1'b0, auto_reset_active = 1'b0;
  logic sync_running = 1'b0, circ_fan_locked_pin = 1'b0;
  logic [2:0] pattern_stage = 3'h0;
  logic running_flag, outputting_flag, run_cmd_accepted, freq_arrival, freq_arrival_alt;
  logic freq_arrival_delayed, freq_detect_a, freq_detect_b, freq_detect_c;
  logic undervoltage_flag, torque_braking, output_limiting, output_limiting_delayed;
  logic power_fail_restart, ready_flag, contactor_control, stage_bit_w1, stage_bit_w2;
  logic stage_bit_w4, fan_flag, auto_reset_flag, universal_out, heatsink_warning;
  logic sync_complete;
  logic [7:0] closure_cnt_q;
  int failures = 0, comparisons = 0;
  assign prelimit_freq = out_freq;
  always #5 mclk = ~mclk;
  dso_status_outputs #(.CYCLES_PER_MS(CPM)) dso_status_outputs_i (.*);
  dso_far_equipment dso_far_equipment_i (.*);
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic fl(input logic got, input logic exp);
    cmp({31'h0, got}, {31'h0, exp});
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] exp, input logic err);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    if (!w) begin
      cmp(prdata, exp);
      fl(pslverr, err);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask
  task automatic det(input logic [15:0] f, input logic e);
    out_freq <= f;
    cyc(3);
    cmp({freq_detect_b, freq_detect_a}, {2{e}});
    fl(freq_detect_c, e);
  endtask
  task automatic conclude();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    conclude();
  end
  initial begin
    cyc(2);
    reset_n <= 1'b1;
    cyc(1);
    apb(1'b0, 12'h000, 32'h0, 32'h1, 1'b0);
    apb(1'b0, 12'h100, 32'h0, 32'h0, 1'b1);
    pattern_active <= 1'b1;
    for (int s = 1; s < 8; s++) begin
      pattern_stage <= 3'(s);
      cyc(2);
      cmp({29'h0, stage_bit_w4, stage_bit_w2, stage_bit_w1}, 32'(s));
    end
    wr(12'h004, 32'h0008_0010);
    wr(12'h008, 32'h000a_0005);
    wr(12'h00c, 32'h0064_0064);
    wr(12'h010, 32'h0100_0064);
    wr(12'h014, 32'h0000_0002);
    det(16'h65, 1'b1);
    det(16'h5f, 1'b1);
    det(16'h59, 1'b0);
    fl(freq_arrival, 1'b0);
    out_freq <= 16'h60;
    cyc(4);
    fl(freq_arrival_alt, 1'b1);
    fl(freq_arrival_delayed, 1'b0);
    cyc(25);
    fl(freq_arrival_delayed, 1'b1);
    fl(running_flag, 1'b1);
    dc_braking <= 1'b1;
    cyc(3);
    fl(running_flag, 1'b0);
    fl(outputting_flag, 1'b1);
    dc_braking <= 1'b0;
    out_freq <= 16'h4;
    cyc(3);
    fl(running_flag, 1'b0);
    wr(12'h000, 32'h5);
    cyc(2);
    fl(running_flag, 1'b1);
    wr(12'h000, 32'h3);
    $display("test frequency done");
    for (int k = 0; k < 4; k++) begin
      torque_value <= k[0] ? 16'hff00 : 16'h0100;
      rotating_reverse <= k[1];
      cyc(2);
      fl(torque_braking, k[0] ^ k[1]);
    end
    for (int k = 0; k < 2; k++) begin
      run_cmd <= 1'b1;
      cyc(4);
      fl(contactor_control, 1'b1);
      coast_cmd <= !k[0];
      alarm <= k[0];
      cyc(3);
      fl(contactor_control, 1'b0);
      run_cmd <= 1'b0;
      coast_cmd <= 1'b0;
      alarm <= 1'b0;
      cyc(2);
    end
    run_cmd <= 1'b1;
    cyc(4);
    run_cmd <= 1'b0;
    stop_cmd <= 1'b1;
    cyc(4);
    fl(contactor_control, 1'b1);
    motor_stopped <= 1'b1;
    cyc(4);
    fl(contactor_control, 1'b0);
    stop_cmd <= 1'b0;
    dc_voltage <= 16'h80;
    cyc(4);
    run_cmd <= 1'b1;
    cyc(4);
    fl(undervoltage_flag, 1'b1);
    fl(contactor_control, 1'b0);
    dc_voltage <= 16'h200;
    cyc(5);
    fl(run_cmd_accepted, 1'b1);
    cmp({24'h0, closure_cnt_q}, 32'h4);
    run_cmd <= 1'b0;
    $display("test contactor done");
    limit_actions <= 4'h2;
    cyc(5 * CPM);
    fl(output_limiting, 1'b1);
    fl(output_limiting_delayed, 1'b0);
    cyc(20 * CPM);
    fl(output_limiting_delayed, 1'b1);
    limit_actions <= 4'h0;
    cyc(50 * CPM);
    fl(output_limiting, 1'b1);
    cyc(60 * CPM);
    fl(output_limiting, 1'b0);
    for (int i = 0; i < 4; i++) begin
      heatsink_temp <= 8'h5e + 8'(i == 1) - 8'(i > 1) - 8'(i > 2);
      cyc(3);
      fl(heatsink_warning, i == 1 || i == 2);
    end
    circ_fan_locked_pin <= 1'b1;
    fan_running <= 1'b1;
    hw_prep_done <= 1'b1;
    auto_reset_active <= 1'b1;
    sync_running <= 1'b1;
    ride_through_run <= 1'b1;
    wr(12'h01c, 32'h1);
    cyc(8);
    fl(heatsink_warning, 1'b1);
    fl(fan_flag, 1'b1);
    fl(ready_flag, 1'b1);
    fl(auto_reset_flag, 1'b1);
    fl(universal_out, 1'b1);
    fl(sync_complete, 1'b1);
    fl(power_fail_restart, 1'b1);
    protect_active <= 1'b1;
    cyc(3);
    fl(ready_flag, 1'b0);
    $display("test outputs done");
    conclude();
  end
endmodule
`default_nettype wire

// file: verilog/dso_map.svh
// Register offsets, field positions, reset values and timing counts of the drive status outputs.
`ifndef DSO_MAP_SVH
`define DSO_MAP_SVH

`define DSO_OFF_CTRL        12'h000
`define DSO_OFF_RUN_FREQ    12'h004
`define DSO_OFF_HYST        12'h008
`define DSO_OFF_DETECT_AB   12'h00c
`define DSO_OFF_DETECT_C_UV 12'h010
`define DSO_OFF_DELAY_TRIP  12'h014
`define DSO_OFF_SYNC_ANGLE  12'h018
`define DSO_OFF_UNIV_DO     12'h01c
`define DSO_OFF_STATUS      12'h020

`define DSO_CTRL_VF_BIT      0
`define DSO_CTRL_FAN_EN_BIT  1
`define DSO_CTRL_INV_RUN_BIT 2
`define DSO_CTRL_INV_OUT_BIT 3

`define DSO_CTRL_RST        32'h0000_0001
`define DSO_RUN_FREQ_RST    32'h0000_0000
`define DSO_HYST_RST        32'h0000_0000
`define DSO_DETECT_AB_RST   32'h0000_0000
`define DSO_DETECT_C_UV_RST 32'h0000_0000
`define DSO_DELAY_TRIP_RST  32'h0000_0000
`define DSO_SYNC_ANGLE_RST  32'h0000_0000

`define DSO_CLK_PERIOD_NS   10
`define DSO_MS_NS           1000000
`define DSO_CYCLES_PER_MS   (`DSO_MS_NS / `DSO_CLK_PERIOD_NS)
`define DSO_LIMIT_MIN_MS    100
`define DSO_LIMIT_DELAY_MS  20
`define DSO_WARN_ON_C       5
`define DSO_WARN_OFF_C      8

`endif

// file: verilog/dso_ms_timer.sv
// Millisecond timer that counts ticks while enabled and flags when a limit is reached.
`default_nettype none
module dso_ms_timer (
  // Clock and reset
  input  wire logic           mclk,
  input  wire logic           reset_n,
  // Control
  input  wire logic           ms_tick,
  input  wire logic           enable,
  input  wire dso_pkg::dso_ms_t limit,
  // Status
  output logic                done
);
  import dso_pkg::*;

  dso_ms_t count_q;
  dso_ms_t count_d;
  wire     at_limit = (count_q >= limit);

  // Saturates at the limit so a long run never wraps back to zero.
  assign count_d = !enable ? 16'h0000 :
                   (ms_tick && !at_limit) ? count_q + 16'h0001 : count_q;
  assign done    = enable && at_limit;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= 16'h0000;
    end else begin
      count_q <= count_d;
    end
  end
endmodule
`default_nettype wire

// file: verilog/dso_pkg.sv
// Types shared by the drive status output logic.
`default_nettype none
package dso_pkg;
  typedef logic [15:0] dso_freq_t;
  typedef logic [7:0]  dso_temp_t;
  typedef logic [15:0] dso_ms_t;
  typedef enum logic [1:0] {
    DSO_MC_OFF,
    DSO_MC_ON,
    DSO_MC_STOPPING
  } dso_mc_e;
endpackage
`default_nettype wire

// file: verilog/dso_status_outputs.sv
// Drive status outputs with their APB configuration registers.
// Operation
// - V/f running follows start and stop frequency
// - Running indication low during DC braking
// - Outputting stays high in braking, excitation, zero-speed
// - Inverted running assignment drives the complement
// - Arrival while frequency error within hysteresis
// - Three detectors set above level, clear below
// - Undervoltage flag; run commands ignored meanwhile
// - Torque polarity low driving, high braking
// - Limiting flag held at least 100 ms
// - Delayed limiting flag after 20 ms continuous
// - Restart flag through ride-through and recovery
// - Ready after preparation, no protection active
// - Contactor on when run command arrives
// - Contactor off after stop, instantly on coast/alarm
// - Pattern stage shown as three-bit code
// - Delayed arrival after configured arrival delay
// - Fan output follows fan when control enabled
// - Auto-reset output during automatic alarm reset
// - Heat warning on trip-5, off trip-8
// - Heat warning also on locked circulation fan
// - Universal output from link-written value only
// - Sync complete inside detection angle
//
// Added by the designer: the APB register port and the address map.
`include "dso_map.svh"
`default_nettype none
module dso_status_outputs #(
  parameter int CYCLES_PER_MS = `DSO_CYCLES_PER_MS
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              reset_n,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Drive measurements
  input  wire dso_pkg::dso_freq_t out_freq,
  input  wire dso_pkg::dso_freq_t ref_freq,
  input  wire dso_pkg::dso_freq_t prelimit_freq,
  input  wire logic [15:0]       dc_voltage,
  input  wire logic signed [15:0] torque_value,
  input  wire logic              rotating_reverse,
  input  wire dso_pkg::dso_temp_t heatsink_temp,
  input  wire dso_pkg::dso_temp_t trip_temp,
  input  wire logic [15:0]       sync_angle_err,
  // Drive state
  input  wire logic              drive_running,
  input  wire logic              dc_braking,
  input  wire logic              pre_excitation,
  input  wire logic              zero_speed_ctl,
  input  wire logic [3:0]        limit_actions,
  input  wire logic              ride_through_run,
  input  wire logic              uv_shutdown,
  input  wire logic              hw_prep_done,
  input  wire logic              protect_active,
  input  wire logic              run_cmd,
  input  wire logic              stop_cmd,
  input  wire logic              coast_cmd,
  input  wire logic              alarm,
  input  wire logic              motor_stopped,
  input  wire logic              pattern_active,
  input  wire logic [2:0]        pattern_stage,
  input  wire logic              fan_running,
  input  wire logic              auto_reset_active,
  input  wire logic              sync_running,
  // Pin from the circulation fan
  input  wire logic              circ_fan_locked_pin,
  // Status outputs
  output logic                   running_flag,
  output logic                   outputting_flag,
  output logic                   run_cmd_accepted,
  output logic                   freq_arrival,
  output logic                   freq_arrival_alt,
  output logic                   freq_arrival_delayed,
  output logic                   freq_detect_a,
  output logic                   freq_detect_b,
  output logic                   freq_detect_c,
  output logic                   undervoltage_flag,
  output logic                   torque_braking,
  output logic                   output_limiting,
  output logic                   output_limiting_delayed,
  output logic                   power_fail_restart,
  output logic                   ready_flag,
  output logic                   contactor_control,
  output logic                   stage_bit_w1,
  output logic                   stage_bit_w2,
  output logic                   stage_bit_w4,
  output logic                   fan_flag,
  output logic                   auto_reset_flag,
  output logic                   universal_out,
  output logic                   heatsink_warning,
  output logic                   sync_complete
);
  import dso_pkg::*;

  function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
    abs_diff = (a >= b) ? a - b : b - a;
  endfunction

  // Hysteresis latch: set above the level, clear below the lower bound, else hold.
  function automatic logic hyst(input logic q, input logic set_c, input logic clr_c);
    hyst = set_c ? 1'b1 : (clr_c ? 1'b0 : q);
  endfunction

  // Registers
  logic [31:0] ctrl_q;
  logic [31:0] run_freq_q;
  logic [31:0] hyst_q;
  logic [31:0] detect_ab_q;
  logic [31:0] detect_c_uv_q;
  logic [31:0] delay_trip_q;
  logic [31:0] sync_angle_q;
  logic        univ_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;

  wire       setup     = psel && !penable;
  wire       wr_access = psel && penable && pready_q && pwrite;
  wire       sel_ctrl  = (paddr == `DSO_OFF_CTRL);
  wire       sel_runf  = (paddr == `DSO_OFF_RUN_FREQ);
  wire       sel_hyst  = (paddr == `DSO_OFF_HYST);
  wire       sel_detab = (paddr == `DSO_OFF_DETECT_AB);
  wire       sel_detc  = (paddr == `DSO_OFF_DETECT_C_UV);
  wire       sel_dly   = (paddr == `DSO_OFF_DELAY_TRIP);
  wire       sel_sync  = (paddr == `DSO_OFF_SYNC_ANGLE);
  wire       sel_univ  = (paddr == `DSO_OFF_UNIV_DO);
  wire       sel_stat  = (paddr == `DSO_OFF_STATUS);
  wire       mapped    = sel_ctrl | sel_runf | sel_hyst | sel_detab | sel_detc |
                         sel_dly | sel_sync | sel_univ | sel_stat;
  wire [31:0] wmask    = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] msk,
                                        input logic [31:0] nw);
    merge = (old & ~msk) | (nw & msk);
  endfunction

  // Field views
  wire        vf_mode     = ctrl_q[`DSO_CTRL_VF_BIT];
  wire        fan_ctl_en  = ctrl_q[`DSO_CTRL_FAN_EN_BIT];
  wire        inv_run     = ctrl_q[`DSO_CTRL_INV_RUN_BIT];
  wire        inv_out     = ctrl_q[`DSO_CTRL_INV_OUT_BIT];
  wire [15:0] start_freq  = run_freq_q[15:0];
  wire [15:0] stop_freq   = run_freq_q[31:16];
  wire [15:0] arr_hyst    = hyst_q[15:0];
  wire [15:0] det_hyst    = hyst_q[31:16];
  wire [15:0] uv_level    = detect_c_uv_q[31:16];
  wire [15:0] arr_delay   = delay_trip_q[15:0];
  wire [15:0] sync_angle  = sync_angle_q[15:0];
  wire [15:0] det_level [3];
  assign det_level[0] = detect_ab_q[15:0];
  assign det_level[1] = detect_ab_q[31:16];
  assign det_level[2] = detect_c_uv_q[15:0];

  // Circulation fan pin synchroniser.
  logic [2:0] fan_sync_q;
  logic       fan_locked_q;
  wire        fan_locked_d = (fan_sync_q[1] == fan_sync_q[2]) ? fan_sync_q[2] : fan_locked_q;

  // Millisecond tick
  logic [31:0] ms_cnt_q;
  logic        ms_tick_q;
  wire         ms_wrap = (ms_cnt_q == 32'(CYCLES_PER_MS - 1));

  // Internal state
  logic       run_state_q;
  logic [2:0] detect_q;
  logic       uv_q;
  logic       limit_q;
  logic       pfr_q;
  logic       warn_q;
  dso_mc_e    mc_q;
  dso_mc_e    mc_d;

  // Comparisons
  wire        run_state_d = vf_mode ? hyst(run_state_q, out_freq > start_freq,
                                           out_freq < stop_freq)
                                    : drive_running;
  wire        arrival_c   = abs_diff(out_freq, ref_freq) <= arr_hyst;
  wire        arrival2_c  = abs_diff(prelimit_freq, ref_freq) <= arr_hyst;
  wire        uv_d        = hyst(uv_q, dc_voltage < uv_level, dc_voltage > uv_level);
  wire        limit_any   = |limit_actions;
  wire        limit_done;
  wire        limit_dly_done;
  wire        arr2_done;
  wire        limit_d     = limit_any || (limit_q && !limit_done);
  wire        pfr_d       = ride_through_run || uv_shutdown || (pfr_q && !arrival_c);
  wire [8:0]  warn_on_t   = {1'b0, trip_temp} - 9'(`DSO_WARN_ON_C);
  wire [8:0]  warn_off_t  = {1'b0, trip_temp} - 9'(`DSO_WARN_OFF_C);
  wire        warn_d      = hyst(warn_q, {1'b0, heatsink_temp} >= warn_on_t,
                                 {1'b0, heatsink_temp} <= warn_off_t);
  wire        run_ok      = run_cmd && !uv_q;
  wire        outputting_c = run_state_q || dc_braking || pre_excitation || zero_speed_ctl;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_detect
      wire [16:0] low_bound = {1'b0, det_level[gi]} - {1'b0, det_hyst};
      wire        clr_c     = !low_bound[16] && ({1'b0, out_freq} < low_bound);
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          detect_q[gi] <= 1'b0;
        end else begin
          detect_q[gi] <= hyst(detect_q[gi], out_freq > det_level[gi], clr_c);
        end
      end
    end
  endgenerate

  // Minimum width counts from the rising edge of the flag itself.
  dso_ms_timer u_limit_min (
    .mclk    (mclk),
    .reset_n (reset_n),
    .ms_tick (ms_tick_q),
    .enable  (limit_q),
    .limit   (16'(`DSO_LIMIT_MIN_MS)),
    .done    (limit_done)
  );

  dso_ms_timer u_limit_delay (
    .mclk    (mclk),
    .reset_n (reset_n),
    .ms_tick (ms_tick_q),
    .enable  (limit_any),
    .limit   (16'(`DSO_LIMIT_DELAY_MS)),
    .done    (limit_dly_done)
  );

  dso_ms_timer u_arrival_delay (
    .mclk    (mclk),
    .reset_n (reset_n),
    .ms_tick (ms_tick_q),
    .enable  (arrival2_c),
    .limit   (arr_delay),
    .done    (arr2_done)
  );

  // Contactor sequencing; coast and alarm win over a simultaneous run command.
  always_comb begin
    mc_d = mc_q;
    unique case (mc_q)
      DSO_MC_OFF:      if (run_ok) mc_d = DSO_MC_ON;
      DSO_MC_ON:       if (stop_cmd) mc_d = DSO_MC_STOPPING;
      DSO_MC_STOPPING: if (motor_stopped) mc_d = DSO_MC_OFF;
                       else if (run_ok && !stop_cmd) mc_d = DSO_MC_ON;
    endcase
    if (coast_cmd || alarm) begin
      mc_d = DSO_MC_OFF;
    end
  end

  // Read data and status view.
  wire [31:0] status_word = {8'h00, sync_complete, heatsink_warning, universal_out,
                             auto_reset_flag, fan_flag, stage_bit_w4, stage_bit_w2,
                             stage_bit_w1, contactor_control, ready_flag,
                             power_fail_restart, output_limiting_delayed,
                             output_limiting, torque_braking, undervoltage_flag,
                             freq_detect_c, freq_detect_b, freq_detect_a,
                             freq_arrival_delayed, freq_arrival_alt, freq_arrival,
                             run_cmd_accepted, outputting_flag, running_flag};
  wire [31:0] rd_mux = sel_ctrl  ? {28'h0, ctrl_q[3:0]} :
                       sel_runf  ? run_freq_q :
                       sel_hyst  ? hyst_q :
                       sel_detab ? detect_ab_q :
                       sel_detc  ? detect_c_uv_q :
                       sel_dly   ? delay_trip_q :
                       sel_sync  ? {16'h0000, sync_angle_q[15:0]} :
                       sel_univ  ? {31'h0, univ_q} :
                       sel_stat  ? status_word : 32'h0000_0000;

  // APB: read data is captured at setup, so no wait states.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && !mapped;
      if (setup && !pwrite) begin
        prdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q        <= `DSO_CTRL_RST;
      run_freq_q    <= `DSO_RUN_FREQ_RST;
      hyst_q        <= `DSO_HYST_RST;
      detect_ab_q   <= `DSO_DETECT_AB_RST;
      detect_c_uv_q <= `DSO_DETECT_C_UV_RST;
      delay_trip_q  <= `DSO_DELAY_TRIP_RST;
      sync_angle_q  <= `DSO_SYNC_ANGLE_RST;
      univ_q        <= 1'b0;
    end else if (wr_access) begin
      if (sel_ctrl) ctrl_q <= merge(ctrl_q, wmask, pwdata) & 32'h0000_000f;
      if (sel_runf) run_freq_q <= merge(run_freq_q, wmask, pwdata);
      if (sel_hyst) hyst_q <= merge(hyst_q, wmask, pwdata);
      if (sel_detab) detect_ab_q <= merge(detect_ab_q, wmask, pwdata);
      if (sel_detc) detect_c_uv_q <= merge(detect_c_uv_q, wmask, pwdata);
      if (sel_dly) delay_trip_q <= merge(delay_trip_q, wmask, pwdata) & 32'h0000_ffff;
      if (sel_sync) sync_angle_q <= merge(sync_angle_q, wmask, pwdata) & 32'h0000_ffff;
      if (sel_univ && pstrb[0]) univ_q <= pwdata[0];
    end
  end

  // Tick, synchroniser and internal state.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ms_cnt_q     <= 32'h0000_0000;
      ms_tick_q    <= 1'b0;
      fan_sync_q   <= 3'h0;
      fan_locked_q <= 1'b0;
      run_state_q  <= 1'b0;
      uv_q         <= 1'b0;
      limit_q      <= 1'b0;
      pfr_q        <= 1'b0;
      warn_q       <= 1'b0;
      mc_q         <= DSO_MC_OFF;
    end else begin
      ms_cnt_q     <= ms_wrap ? 32'h0000_0000 : ms_cnt_q + 32'h0000_0001;
      ms_tick_q    <= ms_wrap;
      fan_sync_q   <= {fan_sync_q[1:0], circ_fan_locked_pin};
      fan_locked_q <= fan_locked_d;
      run_state_q  <= run_state_d;
      uv_q         <= uv_d;
      limit_q      <= limit_d;
      pfr_q        <= pfr_d;
      warn_q       <= warn_d;
      mc_q         <= mc_d;
    end
  end

  // Output flip-flops; all clear on reset so the terminals start inactive.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      running_flag            <= 1'b0;
      outputting_flag         <= 1'b0;
      run_cmd_accepted        <= 1'b0;
      freq_arrival            <= 1'b0;
      freq_arrival_alt        <= 1'b0;
      freq_arrival_delayed    <= 1'b0;
      freq_detect_a           <= 1'b0;
      freq_detect_b           <= 1'b0;
      freq_detect_c           <= 1'b0;
      undervoltage_flag       <= 1'b0;
      torque_braking          <= 1'b0;
      output_limiting         <= 1'b0;
      output_limiting_delayed <= 1'b0;
      power_fail_restart      <= 1'b0;
      ready_flag              <= 1'b0;
      contactor_control       <= 1'b0;
      stage_bit_w1            <= 1'b0;
      stage_bit_w2            <= 1'b0;
      stage_bit_w4            <= 1'b0;
      fan_flag                <= 1'b0;
      auto_reset_flag         <= 1'b0;
      universal_out           <= 1'b0;
      heatsink_warning        <= 1'b0;
      sync_complete           <= 1'b0;
    end else begin
      running_flag            <= (run_state_q && !dc_braking) ^ inv_run;
      outputting_flag         <= outputting_c ^ inv_out;
      run_cmd_accepted        <= run_ok;
      freq_arrival            <= arrival_c;
      freq_arrival_alt        <= arrival_c;
      freq_arrival_delayed    <= arr2_done;
      freq_detect_a           <= detect_q[0];
      freq_detect_b           <= detect_q[1];
      freq_detect_c           <= detect_q[2];
      undervoltage_flag       <= uv_q;
      torque_braking          <= torque_value[15] ^ rotating_reverse;
      output_limiting         <= limit_q;
      output_limiting_delayed <= limit_dly_done;
      power_fail_restart      <= pfr_q;
      ready_flag              <= hw_prep_done && !protect_active;
      contactor_control       <= (mc_q != DSO_MC_OFF);
      stage_bit_w1            <= pattern_active && pattern_stage[0];
      stage_bit_w2            <= pattern_active && pattern_stage[1];
      stage_bit_w4            <= pattern_active && pattern_stage[2];
      fan_flag                <= fan_ctl_en && fan_running;
      auto_reset_flag         <= auto_reset_active;
      universal_out           <= univ_q;
      heatsink_warning        <= warn_q || fan_locked_q;
      sync_complete           <= sync_running && (sync_angle_err <= sync_angle);
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
endmodule
`default_nettype wire
